// ---- src/wcb_top.sv ----
// Write-through two-group data cache with one-write buffered backplane controller
`timescale 1ns/1ps
module wcb_top (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_b,
  input  wire logic                           cpu_req_valid,
  input  wire wcb_pkg::wcb_cmd_t              cpu_cmd,
  input  wire logic                           tb_hit,
  input  wire logic [wcb_pkg::PFN_W-1:0]      page_frame_number,
  input  wire logic [wcb_pkg::BOFF_W-1:0]     byte_offset,
  input  wire wcb_pkg::wcb_md_t               cpu_md,
  output logic                                cpu_stall,
  output logic                                tb_miss_trap,
  output wcb_pkg::wcb_md_t                    memory_data_bus,
  output logic                                md_valid,
  output logic                                md_to_ibuf,
  output logic [wcb_pkg::PA_W-1:0]            physical_address_bus,
  output logic                                bp_req_valid,
  output wcb_pkg::wcb_bp_req_t                bp_req,
  input  wire logic                           bp_grant,
  input  wire logic                           bp_rd_valid,
  input  wire logic [wcb_pkg::DATA_W-1:0]     bp_rd_data
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MISS_WAIT_BUF,
    ST_MISS_REQ,
    ST_MISS_DATA,
    ST_MISS_FILL
  } wcb_state_t;

  wcb_state_t state_r;
  wcb_state_t state_nxt;

  // Physical address formed from the translation
  logic [wcb_pkg::PA_W-1:0]   pa;
  logic [wcb_pkg::IDX_W-1:0]  pa_idx;
  logic [wcb_pkg::TAG_W-1:0]  pa_tag;
  logic                       pa_lw;

  // Lookup results
  logic                       hit0;
  logic                       hit1;
  logic                       cache_hit;
  logic [wcb_pkg::DATA_W-1:0] g0_lw0;
  logic [wcb_pkg::DATA_W-1:0] g0_lw1;
  logic [wcb_pkg::DATA_W-1:0] g1_lw0;
  logic [wcb_pkg::DATA_W-1:0] g1_lw1;
  logic [wcb_pkg::DATA_W-1:0] hit_lw;

  // Request decode
  logic                       take;
  logic                       take_wr;
  logic                       take_rd;
  logic                       rd_hit;
  logic                       rd_miss;
  logic                       trap_cond;

  // Captured reference and miss address latch
  wcb_pkg::wcb_ref_t          ref_r;
  logic [wcb_pkg::PA_W-1:0]   miss_address_latch_r;
  logic                       latch_is_write_r;
  logic                       wbuf_valid_r;
  logic [wcb_pkg::DATA_W-1:0] wbuf_data_r;
  logic [wcb_pkg::BYTES-1:0]  wbuf_mask_r;
  logic                       bp_pending_r;
  logic                       issue_miss;
  logic                       write_load;

  // Quadword collection
  logic [wcb_pkg::DATA_W-1:0] lw0_r;
  logic [wcb_pkg::DATA_W-1:0] lw1_r;
  logic                       lw_cnt_r;
  logic                       rand_bit;
  logic                       fill0;
  logic                       fill1;
  logic [wcb_pkg::DATA_W-1:0] req_lw;

  // Fill address
  logic [wcb_pkg::IDX_W-1:0]  latch_idx;
  logic [wcb_pkg::TAG_W-1:0]  latch_tag;

  // Group enables
  logic                       upd0;
  logic                       upd1;
  logic                       rand_hold;

  assign pa     = {page_frame_number, byte_offset};
  assign pa_idx = pa[wcb_pkg::IDX_LO +: wcb_pkg::IDX_W];
  assign pa_tag = pa[wcb_pkg::TAG_LO +: wcb_pkg::TAG_W];
  assign pa_lw  = pa[wcb_pkg::LW_SEL_BIT];

  assign cache_hit = hit0 || hit1;
  always_comb begin
    if (hit1) begin
      hit_lw = pa_lw ? g1_lw1 : g1_lw0;
    end else begin
      hit_lw = pa_lw ? g0_lw1 : g0_lw0;
    end
  end

  // Stall: busy with a read miss, or a write meets a full buffer
  assign cpu_stall = (state_r != ST_IDLE)
                   || (cpu_req_valid
                       && (cpu_cmd == wcb_pkg::WCB_CMD_WRITE)
                       && wbuf_valid_r);

  // Translation misses are left to microcode, which retries the reference
  assign take    = cpu_req_valid && !cpu_stall && tb_hit
                   && (cpu_cmd != wcb_pkg::WCB_CMD_NOP);
  assign take_wr = take && (cpu_cmd == wcb_pkg::WCB_CMD_WRITE);
  assign take_rd = take && (cpu_cmd != wcb_pkg::WCB_CMD_WRITE);
  assign rd_hit  = take_rd && cache_hit;
  assign rd_miss = take_rd && !cache_hit;

  // Trap on translation miss
  assign trap_cond = cpu_req_valid && !cpu_stall && !tb_hit
                     && (cpu_cmd != wcb_pkg::WCB_CMD_NOP);

  // Latch may take a miss address only once the write has left for the backplane
  assign issue_miss = (state_r == ST_MISS_WAIT_BUF) && !wbuf_valid_r;
  assign write_load = take_wr;

  // Fill writes where the latch points
  assign latch_idx = miss_address_latch_r[wcb_pkg::IDX_LO +: wcb_pkg::IDX_W];
  assign latch_tag = miss_address_latch_r[wcb_pkg::TAG_LO +: wcb_pkg::TAG_W];

  // Write hits update one group only
  assign upd0      = take_wr && hit0;
  assign upd1      = take_wr && hit1 && !hit0;

  // Random bit frozen during a miss
  assign rand_hold = rd_miss || (state_r != ST_IDLE);

  // Group 0 wins a write on a double hit; a read on a double hit returns group 1
  wcb_way u_way0 (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .rd_idx     (pa_idx),
    .rd_tag     (pa_tag),
    .hit        (hit0),
    .rd_lw0     (g0_lw0),
    .rd_lw1     (g0_lw1),
    .fill_en    (fill0),
    .fill_idx   (latch_idx),
    .fill_tag   (latch_tag),
    .fill_lw0   (lw0_r),
    .fill_lw1   (lw1_r),
    .upd_en     (upd0),
    .upd_idx    (pa_idx),
    .upd_lw_sel (pa_lw),
    .upd_mask   (cpu_md.mask),
    .upd_data   (cpu_md.data)
  );

  wcb_way u_way1 (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .rd_idx     (pa_idx),
    .rd_tag     (pa_tag),
    .hit        (hit1),
    .rd_lw0     (g1_lw0),
    .rd_lw1     (g1_lw1),
    .fill_en    (fill1),
    .fill_idx   (latch_idx),
    .fill_tag   (latch_tag),
    .fill_lw0   (lw0_r),
    .fill_lw1   (lw1_r),
    .upd_en     (upd1),
    .upd_idx    (pa_idx),
    .upd_lw_sel (pa_lw),
    .upd_mask   (cpu_md.mask),
    .upd_data   (cpu_md.data)
  );

  // Replacement select
  wcb_rand_bit u_rand (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .hold     (rand_hold),
    .rand_bit (rand_bit)
  );

  assign fill0  = (state_r == ST_MISS_FILL) && !rand_bit;
  assign fill1  = (state_r == ST_MISS_FILL) && rand_bit;
  assign req_lw = miss_address_latch_r[wcb_pkg::LW_SEL_BIT] ? lw1_r : lw0_r;

  // Miss sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rd_miss) begin
          state_nxt = ST_MISS_WAIT_BUF;
        end
      end
      ST_MISS_WAIT_BUF: begin
        // Buffered write goes first
        if (issue_miss) begin
          state_nxt = ST_MISS_REQ;
        end
      end
      ST_MISS_REQ: begin
        if (bp_grant) begin
          state_nxt = ST_MISS_DATA;
        end
      end
      ST_MISS_DATA: begin
        if (bp_rd_valid && lw_cnt_r) begin
          state_nxt = ST_MISS_FILL;
        end
      end
      ST_MISS_FILL: begin
        // Fill group, answer requester
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Address and command captured in the same cycle as the lookup
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ref_r <= '0;
    end else if (take) begin
      ref_r.addr <= pa;
      ref_r.cmd  <= cpu_cmd;
      ref_r.mask <= cpu_md.mask;
    end
  end

  // Shared address latch and one-entry write buffer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      miss_address_latch_r <= wcb_pkg::PA_RST;
      latch_is_write_r     <= 1'b0;
      wbuf_valid_r         <= 1'b0;
      wbuf_data_r          <= wcb_pkg::DATA_RST;
      wbuf_mask_r          <= wcb_pkg::MASK_RST;
    end else begin
      if (write_load) begin
        miss_address_latch_r <= pa;
        latch_is_write_r     <= 1'b1;
        wbuf_valid_r         <= 1'b1;
        wbuf_data_r          <= cpu_md.data;
        wbuf_mask_r          <= cpu_md.mask;
      end else if (issue_miss) begin
        miss_address_latch_r <= {ref_r.addr[wcb_pkg::PA_W-1:wcb_pkg::IDX_LO],
                                 ref_r.addr[wcb_pkg::IDX_LO-1:0]};
        latch_is_write_r     <= 1'b0;
      end else if (bp_grant && bp_pending_r && latch_is_write_r) begin
        wbuf_valid_r <= 1'b0;
      end
    end
  end

  // Backplane request stands until granted
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bp_pending_r <= 1'b0;
    end else if (write_load || issue_miss) begin
      bp_pending_r <= 1'b1;
    end else if (bp_grant) begin
      bp_pending_r <= 1'b0;
    end
  end

  assign bp_req_valid  = bp_pending_r;
  assign bp_req.write  = latch_is_write_r;
  assign bp_req.addr   = latch_is_write_r ? miss_address_latch_r
                       : {miss_address_latch_r[wcb_pkg::PA_W-1:wcb_pkg::IDX_LO], {wcb_pkg::IDX_LO{1'b0}}};
  assign bp_req.data   = latch_is_write_r ? wbuf_data_r : wcb_pkg::DATA_RST;
  assign bp_req.mask   = latch_is_write_r ? wbuf_mask_r : wcb_pkg::MASK_ALL;

  // Quadword returns low longword first
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lw0_r    <= wcb_pkg::DATA_RST;
      lw1_r    <= wcb_pkg::DATA_RST;
      lw_cnt_r <= 1'b0;
    end else if ((state_r == ST_MISS_DATA) && bp_rd_valid) begin
      if (!lw_cnt_r) begin
        lw0_r <= bp_rd_data;
      end else begin
        lw1_r <= bp_rd_data;
      end
      lw_cnt_r <= ~lw_cnt_r;
    end
  end

  // Memory data bus toward datapath or instruction buffer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      memory_data_bus <= '0;
      md_valid        <= 1'b0;
      md_to_ibuf      <= 1'b0;
    end else if (rd_hit) begin
      memory_data_bus.data   <= hit_lw;
      memory_data_bus.parity <= wcb_pkg::wcb_parity(hit_lw);
      memory_data_bus.mask   <= cpu_md.mask;
      md_valid               <= 1'b1;
      md_to_ibuf             <= (cpu_cmd == wcb_pkg::WCB_CMD_RD_IBUF);
    end else if (state_r == ST_MISS_FILL) begin
      memory_data_bus.data   <= req_lw;
      memory_data_bus.parity <= wcb_pkg::wcb_parity(req_lw);
      memory_data_bus.mask   <= ref_r.mask;
      md_valid               <= 1'b1;
      md_to_ibuf             <= (ref_r.cmd == wcb_pkg::WCB_CMD_RD_IBUF);
    end else begin
      md_valid   <= 1'b0;
      md_to_ibuf <= 1'b0;
    end
  end

  // Physical address bus: translated address, or latch redriven for the fill
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      physical_address_bus <= wcb_pkg::PA_RST;
    end else if (state_r == ST_MISS_FILL) begin
      physical_address_bus <= miss_address_latch_r;
    end else if (take) begin
      physical_address_bus <= pa;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tb_miss_trap <= 1'b0;
    end else begin
      tb_miss_trap <= trap_cond;
    end
  end
endmodule : wcb_top

// ---- src/wcb_pkg.sv ----
// Constants and types for the write-through cache and backplane controller
package wcb_pkg;
  localparam int PFN_W      = 21;
  localparam int BOFF_W     = 9;
  localparam int PA_W       = PFN_W + BOFF_W;
  localparam int IDX_LO     = 3;
  localparam int IDX_W      = 9;
  localparam int ENTRIES    = 512;
  localparam int LW_SEL_BIT = 2;
  localparam int TAG_LO     = IDX_LO + IDX_W;
  localparam int TAG_W      = PA_W - TAG_LO;
  localparam int DATA_W     = 32;
  localparam int BYTES      = 4;

  localparam logic              RAND_RST   = 1'b0;
  localparam logic [BYTES-1:0]  MASK_ALL   = 4'hF;
  localparam logic [BYTES-1:0]  MASK_RST   = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST   = 32'h0000_0000;
  localparam logic [PA_W-1:0]   PA_RST     = 30'h0000_0000;

  typedef enum logic [1:0] {
    WCB_CMD_NOP,
    WCB_CMD_RD_DATA,
    WCB_CMD_RD_IBUF,
    WCB_CMD_WRITE
  } wcb_cmd_t;

  // Memory data bus word
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [BYTES-1:0]  parity;
    logic [BYTES-1:0]  mask;
  } wcb_md_t;

  // Reference captured together with the cache
  typedef struct packed {
    logic [PA_W-1:0]  addr;
    wcb_cmd_t         cmd;
    logic [BYTES-1:0] mask;
  } wcb_ref_t;

  // Backplane request
  typedef struct packed {
    logic [PA_W-1:0]   addr;
    logic              write;
    logic [DATA_W-1:0] data;
    logic [BYTES-1:0]  mask;
  } wcb_bp_req_t;

  function automatic logic [BYTES-1:0] wcb_parity(input logic [DATA_W-1:0] d);
    logic [BYTES-1:0] p;
    p = '0;
    for (int b = 0; b < BYTES; b++) begin
      p[b] = ^d[b*8 +: 8];
    end
    return p;
  endfunction : wcb_parity
endpackage : wcb_pkg

// ---- src/wcb_rand_bit.sv ----
// Free-running replacement select bit, frozen while a miss is serviced
`timescale 1ns/1ps
module wcb_rand_bit (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic hold,
  output logic      rand_bit
);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rand_bit <= wcb_pkg::RAND_RST;
    end else if (!hold) begin
      rand_bit <= ~rand_bit;
    end
  end
endmodule : wcb_rand_bit

// ---- src/wcb_way.sv ----
// One cache group: tag, valid and two-longword data storage
`timescale 1ns/1ps
module wcb_way #(
  parameter int IDX_W   = wcb_pkg::IDX_W,
  parameter int TAG_W   = wcb_pkg::TAG_W,
  parameter int DATA_W  = wcb_pkg::DATA_W,
  parameter int BYTES   = wcb_pkg::BYTES,
  parameter int ENTRIES = wcb_pkg::ENTRIES
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic [IDX_W-1:0]  rd_idx,
  input  wire logic [TAG_W-1:0]  rd_tag,
  output logic                   hit,
  output logic [DATA_W-1:0]      rd_lw0,
  output logic [DATA_W-1:0]      rd_lw1,
  input  wire logic              fill_en,
  input  wire logic [IDX_W-1:0]  fill_idx,
  input  wire logic [TAG_W-1:0]  fill_tag,
  input  wire logic [DATA_W-1:0] fill_lw0,
  input  wire logic [DATA_W-1:0] fill_lw1,
  input  wire logic              upd_en,
  input  wire logic [IDX_W-1:0]  upd_idx,
  input  wire logic              upd_lw_sel,
  input  wire logic [BYTES-1:0]  upd_mask,
  input  wire logic [DATA_W-1:0] upd_data
);
  logic [TAG_W-1:0]  tag_mem [ENTRIES];
  logic [DATA_W-1:0] lw0_mem [ENTRIES];
  logic [DATA_W-1:0] lw1_mem [ENTRIES];
  logic [ENTRIES-1:0] valid_r;

  assign hit    = valid_r[rd_idx] && (tag_mem[rd_idx] == rd_tag);
  assign rd_lw0 = lw0_mem[rd_idx];
  assign rd_lw1 = lw1_mem[rd_idx];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      valid_r <= '0;
    end else if (fill_en) begin
      valid_r[fill_idx] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fill_en) begin
      tag_mem[fill_idx] <= fill_tag;
      lw0_mem[fill_idx] <= fill_lw0;
      lw1_mem[fill_idx] <= fill_lw1;
    end else if (upd_en) begin
      for (int b = 0; b < BYTES; b++) begin
        if (upd_mask[b] && !upd_lw_sel) begin
          lw0_mem[upd_idx][b*8 +: 8] <= upd_data[b*8 +: 8];
        end
        if (upd_mask[b] && upd_lw_sel) begin
          lw1_mem[upd_idx][b*8 +: 8] <= upd_data[b*8 +: 8];
        end
      end
    end
  end
endmodule : wcb_way

// ---- bench/wcb_assertions.sv ----
// Port-level checker for the write-through cache and backplane controller
`timescale 1ns/1ps
module wcb_assertions (
  input wire logic                       clk_sys,
  input wire logic                       rst_b,
  input wire logic                       cpu_req_valid,
  input wire wcb_pkg::wcb_cmd_t          cpu_cmd,
  input wire logic                       tb_hit,
  input wire logic [wcb_pkg::PFN_W-1:0]  page_frame_number,
  input wire logic [wcb_pkg::BOFF_W-1:0] byte_offset,
  input wire wcb_pkg::wcb_md_t           cpu_md,
  input wire logic                       cpu_stall,
  input wire logic                       tb_miss_trap,
  input wire wcb_pkg::wcb_md_t           memory_data_bus,
  input wire logic                       md_valid,
  input wire logic                       md_to_ibuf,
  input wire logic [wcb_pkg::PA_W-1:0]   physical_address_bus,
  input wire logic                       bp_req_valid,
  input wire wcb_pkg::wcb_bp_req_t       bp_req,
  input wire logic                       bp_grant
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic                     ask = cpu_req_valid && !cpu_stall && tb_hit;
  wire logic                     nop = cpu_cmd == wcb_pkg::WCB_CMD_NOP;
  wire logic                     wr  = ask && cpu_cmd == wcb_pkg::WCB_CMD_WRITE;
  wire logic                     rd  = ask && !nop && !wr;
  wire logic                     brd = bp_req_valid && !bp_req.write;
  wire logic [wcb_pkg::PA_W-1:0] pa  = {page_frame_number, byte_offset};
  wire logic [3:0]               par = {^memory_data_bus.data[31:24], ^memory_data_bus.data[23:16],
                                        ^memory_data_bus.data[15:8], ^memory_data_bus.data[7:0]};

  property p_rst_idle; $rose(rst_b) |-> !bp_req_valid && !md_valid && !cpu_stall; endproperty
  property p_physical_address_bus; ask && !nop |=> physical_address_bus == $past(pa); endproperty
  property p_wr_fwd;
    wr |=> bp_req_valid && bp_req.write && bp_req.addr == $past(pa) && bp_req.data == $past(cpu_md.data)
      && bp_req.mask == $past(cpu_md.mask);
  endproperty
  property p_req_hold; bp_req_valid && !bp_grant |=> bp_req_valid && $stable(bp_req); endproperty
  property p_rd_aligned; brd |-> bp_req.addr[2:0] == 3'h0 && bp_req.mask == 4'hF; endproperty
  property p_miss_stall; brd |-> cpu_stall; endproperty
  property p_wr_stall; bp_req_valid && bp_req.write && cpu_req_valid && cpu_cmd == wcb_pkg::WCB_CMD_WRITE |-> cpu_stall;
  endproperty
  property p_rd_answer; rd && !bp_req_valid |-> ##1 md_valid or ##2 (brd && cpu_stall); endproperty
  property p_trap; cpu_req_valid && !cpu_stall && !tb_hit && !nop |=> tb_miss_trap && !md_valid; endproperty
  property p_parity; md_valid |-> memory_data_bus.parity == par; endproperty
  property p_ibuf; md_to_ibuf |-> md_valid; endproperty

  a_rst_idle:   assert property (p_rst_idle) else $error("busy right after reset");
  a_physical_address_bus:     assert property (p_physical_address_bus) else $error("address bus mismatch");
  a_wr_fwd:     assert property (p_wr_fwd) else $error("write not forwarded");
  a_req_hold:   assert property (p_req_hold) else $error("request changed before grant");
  a_rd_aligned: assert property (p_rd_aligned) else $error("read not quadword");
  a_miss_stall: assert property (p_miss_stall) else $error("no stall during miss");
  a_wr_stall:   assert property (p_wr_stall) else $error("second write not stalled");
  a_rd_answer:  assert property (p_rd_answer) else $error("read neither answered nor fetched");
  a_trap:       assert property (p_trap) else $error("no trap on translation miss");
  a_parity:     assert property (p_parity) else $error("bad data bus parity");
  a_ibuf:       assert property (p_ibuf) else $error("ibuf flag without data");

  c_hit:   cover property (rd ##1 md_valid);
  c_wr2:   cover property (wr ##1 (cpu_req_valid && cpu_cmd == wcb_pkg::WCB_CMD_WRITE && cpu_stall));
  c_miss:  cover property (brd && bp_grant);
endmodule : wcb_assertions

bind wcb_top wcb_assertions wcb_assertions_inst (.clk_sys, .rst_b, .cpu_req_valid, .cpu_cmd, .tb_hit,
  .page_frame_number, .byte_offset, .cpu_md, .cpu_stall, .tb_miss_trap, .memory_data_bus, .md_valid,
  .md_to_ibuf, .physical_address_bus, .bp_req_valid, .bp_req, .bp_grant);

// ---- bench/wcb_mem_model.sv ----
// Behavioural backplane memory: grants requests, merges writes, returns quadwords
`timescale 1ns/1ps
module wcb_mem_model (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  slow,
  input  wire logic                  bp_req_valid,
  input  wire wcb_pkg::wcb_bp_req_t  bp_req,
  output logic                       bp_grant,
  output logic                       bp_rd_valid,
  output logic [wcb_pkg::DATA_W-1:0] bp_rd_data
);
  logic [31:0]          mem [int];
  logic [31:0]          w;
  wcb_pkg::wcb_bp_req_t r;

  function automatic logic [31:0] word(input int a);
    return mem.exists(a) ? mem[a] : 32'h5A00_0000 ^ a;
  endfunction : word

  initial begin
    bp_grant = 1'b0;
    bp_rd_valid = 1'b0;
    bp_rd_data = 32'h0000_0000;
    forever begin
      @(negedge clk_sys);
      if (rst_b && bp_req_valid) begin
        r = bp_req;
        repeat (slow ? $urandom_range(6, 1) : 1) @(posedge clk_sys);
        #1 bp_grant = 1'b1;
        @(posedge clk_sys);
        #1 bp_grant = 1'b0;
        if (r.write) begin
          w = word(int'(r.addr >> 2));
          for (int b = 0; b < 4; b++) begin
            if (r.mask[b]) w[b*8 +: 8] = r.data[b*8 +: 8];
          end
          mem[int'(r.addr >> 2)] = w;
        end else begin
          for (int k = 0; k < 2; k++) begin
            repeat (slow ? $urandom_range(3, 1) : 1) @(posedge clk_sys);
            #1 bp_rd_valid = 1'b1;
            bp_rd_data = word(int'(r.addr >> 2) + k);
            @(posedge clk_sys);
            #1 bp_rd_valid = 1'b0;
            bp_rd_data = ~bp_rd_data;
          end
        end
      end
    end
  end
endmodule : wcb_mem_model

// ---- bench/wcb_top_tb.sv ----
// Self-checking bench for the write-through cache and backplane controller
`timescale 1ns/1ps
module wcb_top_tb;
  logic                 clk_sys, rst_b, cpu_req_valid, tb_hit, cpu_stall, tb_miss_trap, md_valid, md_to_ibuf;
  logic                 bp_req_valid, bp_grant, bp_rd_valid, slow;
  wcb_pkg::wcb_cmd_t    cpu_cmd;
  logic [20:0]          page_frame_number;
  logic [8:0]           byte_offset;
  logic [29:0]          physical_address_bus;
  wcb_pkg::wcb_md_t     cpu_md, memory_data_bus;
  wcb_pkg::wcb_bp_req_t bp_req;
  logic [31:0]          bp_rd_data;
  logic [31:0]          shadow [int];
  logic [70:0]          md_q [$];
  wcb_pkg::wcb_bp_req_t wr_q [$];
  int                   miscompares, cmp_count, n, lat;

  wcb_top wcb_top_inst (.clk_sys, .rst_b, .cpu_req_valid, .cpu_cmd, .tb_hit, .page_frame_number, .byte_offset,
    .cpu_md, .cpu_stall, .tb_miss_trap, .memory_data_bus, .md_valid, .md_to_ibuf, .physical_address_bus,
    .bp_req_valid, .bp_req, .bp_grant, .bp_rd_valid, .bp_rd_data);
  wcb_mem_model wcb_mem_model_inst (.clk_sys, .rst_b, .slow, .bp_req_valid, .bp_req, .bp_grant, .bp_rd_valid,
    .bp_rd_data);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic timeout;
    miscompares++;
    $display("CHECK FAILED wait expected done seen timeout");
    stop_test;
  endtask : timeout

  task automatic chk_md(input string nm, input logic [70:0] e, input logic [70:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_md

  task automatic chk_req(input string nm, input wcb_pkg::wcb_bp_req_t e, input wcb_pkg::wcb_bp_req_t g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_req

  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  function automatic logic [31:0] exp_word(input logic [29:0] a);
    return shadow.exists(int'(a >> 2)) ? shadow[int'(a >> 2)] : 32'h5A00_0000 ^ (a >> 2);
  endfunction : exp_word

  function automatic logic [70:0] exp_md(input logic ib, input logic [29:0] a, input logic [3:0] m);
    logic [31:0] w;
    w = exp_word(a);
    return {a, ib, w, ^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0], m};
  endfunction : exp_md

  // Captures answers and granted writes while both are settled
  always @(negedge clk_sys) begin
    if (md_valid === 1'b1) md_q.push_back({physical_address_bus, md_to_ibuf, memory_data_bus});
    if (bp_req_valid === 1'b1 && bp_grant === 1'b1 && bp_req.write === 1'b1) begin
      if (wr_q.size() == 0) chk_req("unexpected write", '0, bp_req);
      else chk_req("memory write", wr_q.pop_front(), bp_req);
    end
  end

  task automatic issue(input wcb_pkg::wcb_cmd_t c, input logic [29:0] a, input logic [31:0] d,
                       input logic [3:0] m, input logic th);
    logic [31:0] w;
    @(posedge clk_sys);
    #1;
    cpu_req_valid = 1'b1;
    cpu_cmd = c;
    tb_hit = th;
    {page_frame_number, byte_offset} = a;
    cpu_md = {d, 4'h0, m};
    n = 0;
    @(negedge clk_sys);
    while (cpu_stall !== 1'b0 && n < 300) begin
      n++;
      @(negedge clk_sys);
    end
    if (n == 300) timeout;
    @(posedge clk_sys);
    #1 cpu_req_valid = 1'b0;
    if (c == wcb_pkg::WCB_CMD_WRITE && th) begin
      wr_q.push_back({a, 1'b1, d, m});
      w = exp_word(a);
      for (int b = 0; b < 4; b++) begin
        if (m[b]) w[b*8 +: 8] = d[b*8 +: 8];
      end
      shadow[int'(a >> 2)] = w;
    end
  endtask : issue

  task automatic get_md(input logic ib, input logic [29:0] a, input logic [3:0] m);
    lat = 0;
    while (md_q.size() == 0 && lat < 300) begin
      @(posedge clk_sys);
      lat++;
    end
    #1;
    if (md_q.size() == 0) timeout;
    chk_md("read data", exp_md(ib, a, m), md_q.pop_front());
  endtask : get_md

  initial begin
    logic [29:0]       a;
    logic [31:0]       d;
    logic [3:0]        m;
    logic              th;
    wcb_pkg::wcb_cmd_t c;
    {cpu_req_valid, tb_hit, slow, page_frame_number, byte_offset} = '0;
    cpu_cmd = wcb_pkg::WCB_CMD_NOP;
    cpu_md = '0;
    rst_b = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    n = $urandom(32'h0289);
    repeat (8) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    @(posedge clk_sys);
    #1;
    issue(wcb_pkg::WCB_CMD_RD_DATA, 30'h0000_1008, 32'h0, 4'hF, 1'b1);
    get_md(1'b0, 30'h0000_1008, 4'hF);
    chk_bit("cold miss", 1'b1, lat > 1);
    issue(wcb_pkg::WCB_CMD_RD_IBUF, 30'h0000_100C, 32'h0, 4'h3, 1'b1);
    get_md(1'b1, 30'h0000_100C, 4'h3);
    chk_bit("quadword hit", 1'b1, lat == 1);
    issue(wcb_pkg::WCB_CMD_WRITE, 30'h0000_1008, 32'hCAFE_0123, 4'h5, 1'b1);
    issue(wcb_pkg::WCB_CMD_RD_DATA, 30'h0000_1008, 32'h0, 4'hF, 1'b1);
    get_md(1'b0, 30'h0000_1008, 4'hF);
    chk_bit("write hit updates", 1'b1, lat == 1);
    issue(wcb_pkg::WCB_CMD_WRITE, 30'h0002_2010, 32'h1357_9BDF, 4'hF, 1'b1);
    issue(wcb_pkg::WCB_CMD_RD_DATA, 30'h0002_2010, 32'h0, 4'hF, 1'b1);
    get_md(1'b0, 30'h0002_2010, 4'hF);
    chk_bit("write miss not allocated", 1'b1, lat > 1);
    $display("test directed_hits done");
    slow = 1'b1;
    issue(wcb_pkg::WCB_CMD_WRITE, 30'h0000_2000, 32'h1111_2222, 4'hF, 1'b1);
    issue(wcb_pkg::WCB_CMD_WRITE, 30'h0000_2004, 32'h3333_4444, 4'hC, 1'b1);
    chk_bit("second write stalls", 1'b1, n > 0);
    issue(wcb_pkg::WCB_CMD_RD_IBUF, 30'h0003_3000, 32'h0, 4'hF, 1'b1);
    issue(wcb_pkg::WCB_CMD_WRITE, 30'h0003_3100, 32'h5555_6666, 4'hF, 1'b1);
    chk_bit("read returned before write", 1'b1, md_q.size() > 0);
    get_md(1'b1, 30'h0003_3000, 4'hF);
    issue(wcb_pkg::WCB_CMD_RD_DATA, 30'h0004_4000, 32'h0, 4'hF, 1'b0);
    @(negedge clk_sys);
    chk_bit("translation trap", 1'b1, tb_miss_trap);
    @(posedge clk_sys);
    #1;
    issue(wcb_pkg::WCB_CMD_NOP, 30'h0000_1008, 32'h0, 4'hF, 1'b0);
    @(negedge clk_sys);
    chk_bit("nop ignored", 1'b0, tb_miss_trap | md_valid);
    $display("test directed_stalls done");
    for (int i = 0; i < 80; i++) begin
      slow = 1'($urandom);
      c = wcb_pkg::wcb_cmd_t'($urandom_range(3, 1));
      a = {16'h0, 2'($urandom_range(3, 0)), 6'h0, 3'($urandom_range(7, 0)), 1'($urandom), 2'h0};
      d = $urandom;
      m = 4'($urandom_range(15, 1));
      th = $urandom_range(9, 0) != 0;
      issue(c, a, d, m, th);
      if (!th) begin
        @(negedge clk_sys);
        chk_bit("translation trap", 1'b1, tb_miss_trap);
        @(posedge clk_sys);
        #1;
      end else if (c != wcb_pkg::WCB_CMD_WRITE) begin
        get_md(c == wcb_pkg::WCB_CMD_RD_IBUF, a, m);
      end
    end
    n = 0;
    while (wr_q.size() != 0 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    chk_bit("write buffer drained", 1'b1, wr_q.size() == 0);
    $display("test random_mix done");
    stop_test;
  end
endmodule : wcb_top_tb
